// *** rtl/alarm_led_regs.vh ***
// Purpose: constants for the alarm and LED status block
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz clock
// Notes: offsets are byte addresses
`ifndef ALARM_LED_REGS_VH
`define ALARM_LED_REGS_VH
`define CLK_HZ             100000000
`define BLINK_HZ           1
`define PG_PULSE_MS        1
`define OFS_COND           8'h00
`define OFS_CTRL           8'h04
`define OFS_FAULT_LATCH    8'h08
`define OFS_BUS_STATUS     8'h0C
`define OFS_OC_RESP        8'h10
`define OFS_OT_RESP        8'h14
`define OFS_PIN_STATE      8'h18
`define OFS_CMD            8'h1C
`define CTRL_RESET         32'h0000_0000
`define RESP_RESET         8'h00
`define BUS_REJECT_BIT     0
`define BUS_TAKEOVER_BIT   2
`define BUS_CLEAR_BIT      4
`define FAULT_BITS         10
`define OK_RESP            2'b00
`define SLVERR_RESP        2'b10
`endif

// *** rtl/alarm_led_status.v ***
// Purpose: Maps rectifier conditions to four LEDs and open-drain alarms; arbitrates two host ports
// Assumes: Condition inputs are synchronous to aclk; pins are synchronised here
// Notes: Notes on behaviour follow
// Notes on behaviour
// RULE1 - Near thermal shutdown: amber on, greens on, only overtemp warning low.
// RULE2 - Overtemp warning idles high, goes low 5C before thermal shutdown.
// RULE3 - Fuse, boost or latched overvoltage: input on, output off, fault on, alarms low; overtemp warning stays high here.
// RULE4 - Input out of limits: input LED blinks, others off, power-good low.
// RULE5 - Overload: output LED blinks, power-good pulses 1ms while overloaded, fault high.
// RULE6 - Non-shutdown fault: fault LED on, greens on, fault low, power-good high.
// RULE7 - PMBus service request blinks amber, greens on, alarms high.
// RULE8 - RS485 comm loss blinks red, greens on, alarms high.
// RULE9 - One fan failure raises fault; two fans fail means immediate shutdown.
// RULE10 - Fault, power-good and overtemp alarms are active-low open drain.
// RULE11 - In analog or PMBus mode output enabled only while enable input low.
// RULE12 - Power-good goes low when output loss is predicted.
// RULE13 - Link select open picks PMBus, resistor-tied picks RS485.
// RULE14 - Low four address bits come from slot and shelf address levels.
// RULE15 - Only the controlling port clears status; host reads status before clearing.
// RULE16 - A clear from the controlling port keeps the other port's alert.
// RULE17 - Supply alarms never set bus arbitration status bits.
// RULE18 - Command from non-controlling port is rejected, logged, and alerts that port.
// RULE19 - Fault bits sticky until cleared; persisting fault reasserts; state bits don't latch.
// RULE20 - Shutdown, OR-ing test, warnings, faults, command errors all latch.
// RULE21 - Overcurrent and overtemp response settings change only by explicit command.
// RULE22 - LED blink is a configurable roughly 1 Hz, 50 percent duty prescaled pattern.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "alarm_led_regs.vh"
module alarm_led_status #(
  parameter integer CLK_HZ   = `CLK_HZ,
  parameter integer BLINK_HZ = `BLINK_HZ,
  parameter integer PULSE_MS = `PG_PULSE_MS
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Conditions from rectifier logic
  input  wire        input_ok,
  input  wire        input_present,
  input  wire        near_thermal_limit,
  input  wire        thermal_shutdown,
  input  wire [1:0]  fan_fail,
  input  wire        fuse_blown,
  input  wire        boost_fail,
  input  wire        ov_latched,
  input  wire        overload,
  input  wire        internal_fault,
  input  wire        standby,
  input  wire        output_loss_predict,
  input  wire        service_request,
  input  wire        comm_lost,
  input  wire        oring_test_done,
  input  wire        cmd_error,
  // Pins
  input  wire        on_off_pin_n,
  input  wire        link_sel_pin,
  input  wire [3:0]  slot_addr_level,
  input  wire [3:0]  shelf_addr_level,
  // Outputs
  output reg         led_input,
  output reg         led_output,
  output reg         led_service,
  output reg         led_fault,
  output reg         fault_out,
  output reg         fault_oe,
  output reg         output_good_n_out,
  output reg         output_good_n_oe,
  output reg         overtemp_warn_n_out,
  output reg         overtemp_warn_n_oe,
  output reg         presence_out,
  output reg         main_output_en,
  output reg         rs485_mode,
  output reg  [3:0]  bus_addr_low,
  output reg         port0_alert_n,
  output reg         port1_alert_n
);
  localparam integer BLINK_HALF = CLK_HZ / (2 * BLINK_HZ);
  localparam integer PULSE_CYC  = (CLK_HZ / 1000) * PULSE_MS;

  // Two-flop synchronisers for pins
  reg  [9:0] pin_s1;
  reg  [9:0] pin_s2;
  always @(posedge aclk)
  begin
    pin_s1 <= {on_off_pin_n, link_sel_pin, slot_addr_level, shelf_addr_level};
    pin_s2 <= pin_s1;
  end
  wire       on_off_n = pin_s2[9];
  wire       link_sel = pin_s2[8];

  // Blink and power-good pulse prescalers
  reg [31:0] blink_cnt;
  reg        blink;
  reg [31:0] pulse_cnt;
  reg        pulse;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
      pulse_cnt <= 32'h0000_0000;
      pulse     <= 1'b0;
    end
    else
    begin
      if (blink_cnt >= BLINK_HALF - 1) // [RULE22]
      begin
        blink_cnt <= 32'h0000_0000;
        blink     <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h0000_0001;
      if (pulse_cnt >= PULSE_CYC - 1) // [RULE5]
      begin
        pulse_cnt <= 32'h0000_0000;
        pulse     <= ~pulse;
      end
      else
        pulse_cnt <= pulse_cnt + 32'h0000_0001;
    end
  end

  // Registers
  reg        control_port;
  reg [31:0] ctrl;
  reg [`FAULT_BITS-1:0] fault_latch;
  reg [7:0]  bus_status;
  reg [7:0]  oc_resp;
  reg [7:0]  ot_resp;
  reg        alert0;
  reg        alert1;

  // Write channel: address and data accepted separately in any order, written once both are present
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire       aw_now  = aw_held | s_axi_awvalid;
  wire       w_now   = w_held | s_axi_wvalid;
  wire [7:0] wa      = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd     = w_held ? w_data : s_axi_wdata;
  wire       do_wr   = aw_now && w_now && !s_axi_bvalid;

  // Command register: bit0 port, bit1 clear-faults, bit2 take control
  wire       cmd_wr    = do_wr && wa == `OFS_CMD;
  wire       cmd_port  = wd[0];
  wire       from_ctl  = cmd_port == control_port;
  wire       clr       = cmd_wr && wd[1] && from_ctl;
  wire       take      = cmd_wr && wd[2];
  wire       reject    = cmd_wr && !from_ctl && !wd[2];

  // Live fault vector
  wire       shutdown   = thermal_shutdown | fuse_blown | boost_fail | ov_latched | (&fan_fail); // [RULE9]
  wire [`FAULT_BITS-1:0] fault_now = {cmd_error, internal_fault, oring_test_done, (|fan_fail), overload,
    ov_latched, (input_present & !input_ok), near_thermal_limit, thermal_shutdown, shutdown};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OK_RESP;
      ctrl         <= `CTRL_RESET;
      control_port <= 1'b0;
      fault_latch  <= {`FAULT_BITS{1'b0}};
      bus_status   <= 8'h00;
      oc_resp      <= `RESP_RESET;
      ot_resp      <= `RESP_RESET;
      alert0       <= 1'b0;
      alert1       <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !do_wr)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Latch faults; a persisting fault reasserts even in a clearing cycle
      if (clr)
        fault_latch <= fault_now; // [RULE15] [RULE19]
      else
        fault_latch <= fault_latch | fault_now; // [RULE20]
      if (do_wr)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OK_RESP;
        case (wa)
          `OFS_CTRL:
          begin
            if (s_axi_wstrb[0])
              ctrl[7:0] <= wd[7:0];
          end
          `OFS_OC_RESP:
          begin
            if (s_axi_wstrb[0] && from_ctl)
              oc_resp <= wd[7:0]; // [RULE21]
          end
          `OFS_OT_RESP:
          begin
            if (s_axi_wstrb[0] && from_ctl)
              ot_resp <= wd[7:0]; // [RULE21]
          end
          `OFS_CMD:
          begin
            if (take)
            begin
              control_port <= cmd_port;
              bus_status   <= bus_status | (8'h01 << `BUS_TAKEOVER_BIT);
              if (cmd_port)
                alert1 <= 1'b1;
              else
                alert0 <= 1'b1;
            end
            else if (reject)
            begin
              bus_status <= bus_status | (8'h01 << `BUS_REJECT_BIT); // [RULE18]
              if (cmd_port)
                alert1 <= 1'b1;
              else
                alert0 <= 1'b1;
            end
            else if (clr)
            begin
              // Only the controlling port's alert drops; supply alarms never touch bus status
              bus_status <= 8'h01 << `BUS_CLEAR_BIT; // [RULE17]
              if (control_port)
                alert1 <= 1'b0; // [RULE16]
              else
                alert0 <= 1'b0; // [RULE16]
            end
          end
          `OFS_COND, `OFS_FAULT_LATCH, `OFS_BUS_STATUS, `OFS_PIN_STATE:
            s_axi_bresp <= `OK_RESP;
          default:
            s_axi_bresp <= `SLVERR_RESP;
        endcase
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OK_RESP;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `OK_RESP;
      case (s_axi_araddr)
        `OFS_COND:        s_axi_rdata <= {22'h00_0000, fault_now};
        `OFS_CTRL:        s_axi_rdata <= ctrl;
        `OFS_FAULT_LATCH: s_axi_rdata <= {22'h00_0000, fault_latch};
        `OFS_BUS_STATUS:  s_axi_rdata <= {23'h00_0000, control_port, bus_status};
        `OFS_OC_RESP:     s_axi_rdata <= {24'h00_0000, oc_resp};
        `OFS_OT_RESP:     s_axi_rdata <= {24'h00_0000, ot_resp};
        `OFS_PIN_STATE:   s_axi_rdata <= {22'h00_0000, on_off_n, link_sel, pin_s2[7:0]};
        `OFS_CMD:         s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SLVERR_RESP;
        end
      endcase
    end
  end

  // LED and alarm mapping, highest priority first
  reg n_in, n_out, n_svc, n_flt, n_fault_lo, n_pg_lo, n_otw_lo;
  wire analog_mode = ctrl[0];
  always @*
  begin
    n_in = 1'b1;
    n_out = 1'b1;
    n_svc = 1'b0;
    n_flt = 1'b0;
    n_fault_lo = 1'b0;
    n_pg_lo = output_loss_predict; // [RULE12]
    n_otw_lo = 1'b0;
    if (thermal_shutdown)
    begin
      n_out = 1'b0;
      n_svc = 1'b1;
      n_flt = 1'b1;
      n_fault_lo = 1'b1;
      n_pg_lo = 1'b1;
      n_otw_lo = 1'b1;
    end
    else if (fuse_blown || boost_fail || ov_latched || (&fan_fail)) // [RULE3] [RULE9]
    begin
      n_out = 1'b0;
      n_flt = 1'b1;
      n_fault_lo = 1'b1;
      n_pg_lo = 1'b1;
    end
    else if (!input_present)
    begin
      n_in = 1'b0;
      n_out = 1'b0;
      n_pg_lo = 1'b1;
    end
    else if (!input_ok)
    begin
      n_in = blink; // [RULE4]
      n_out = 1'b0;
      n_pg_lo = 1'b1;
    end
    else if (overload)
    begin
      n_out = blink; // [RULE5]
      n_pg_lo = pulse | output_loss_predict; // [RULE5] [RULE12]
    end
    else if (standby)
    begin
      n_out = 1'b0;
      n_pg_lo = 1'b1;
    end
    else if ((|fan_fail) || internal_fault)
    begin
      n_flt = 1'b1; // [RULE6] [RULE9]
      n_fault_lo = 1'b1;
    end
    else if (near_thermal_limit)
    begin
      n_svc = 1'b1; // [RULE1]
      n_otw_lo = 1'b1; // [RULE2]
    end
    else if (service_request && !link_sel)
      n_svc = blink; // [RULE7]
    else if (comm_lost && link_sel)
      n_flt = blink; // [RULE8]
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_input <= 1'b0;
      led_output <= 1'b0;
      led_service <= 1'b0;
      led_fault <= 1'b0;
      fault_out <= 1'b0;
      fault_oe <= 1'b0;
      output_good_n_out <= 1'b0;
      output_good_n_oe <= 1'b0;
      overtemp_warn_n_out <= 1'b0;
      overtemp_warn_n_oe <= 1'b0;
      presence_out <= 1'b0;
      main_output_en <= 1'b0;
      rs485_mode <= 1'b0;
      bus_addr_low <= 4'h0;
      port0_alert_n <= 1'b1;
      port1_alert_n <= 1'b1;
    end
    else
    begin
      led_input <= n_in;
      led_output <= n_out;
      led_service <= n_svc;
      led_fault <= n_flt;
      // Open drain: output always low, enable pulls the line
      fault_out <= 1'b0;
      fault_oe <= n_fault_lo; // [RULE10]
      output_good_n_out <= 1'b0;
      output_good_n_oe <= n_pg_lo; // [RULE10]
      overtemp_warn_n_out <= 1'b0;
      overtemp_warn_n_oe <= n_otw_lo; // [RULE10]
      presence_out <= 1'b0;
      rs485_mode <= link_sel; // [RULE13]
      main_output_en <= (analog_mode || !link_sel) ? (!on_off_n && !shutdown) : !shutdown; // [RULE11]
      bus_addr_low <= pin_s2[7:4] ^ pin_s2[3:0]; // [RULE14]
      port0_alert_n <= !alert0;
      port1_alert_n <= !alert1;
    end
  end
endmodule

// *** verification/alarm_led_checker.sv ***
// Purpose: Concurrent checks on LEDs, alarm drivers and pin decoding
// Assumes: One clock domain, synchronous active-low reset
// Notes: Mode and address checks wait five cycles, the on/off check seven, so the synchronisers have settled
`timescale 1ns/1ps
module alarm_led_checker (
  // Clock, reset and conditions
  input wire       aclk, aresetn, input_ok, input_present, near_thermal_limit, thermal_shutdown,
  input wire [1:0] fan_fail,
  input wire       fuse_blown, boost_fail, ov_latched, overload, internal_fault, standby, output_loss_predict,
  // Pins and outputs
  input wire       on_off_pin_n, link_sel_pin,
  input wire [3:0] slot_addr_level, shelf_addr_level, bus_addr_low,
  input wire       led_input, led_output, led_service, led_fault, fault_out, fault_oe, output_good_n_out,
  input wire       output_good_n_oe, overtemp_warn_n_out, overtemp_warn_n_oe, main_output_en, rs485_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire       hard  = thermal_shutdown | fuse_blown | boost_fail | ov_latched | (&fan_fail);
  wire       quiet = input_ok & input_present & !hard & !overload & !standby & !output_loss_predict;
  wire       base  = quiet & (fan_fail == 2'b00) & !internal_fault;
  logic [2:0] off_cnt;
  // Saturating count of cycles the on/off pin has been high
  always @(posedge aclk)
    if (!aresetn || !on_off_pin_n)
      off_cnt <= 3'd0;
    else if (off_cnt != 3'd7)
      off_cnt <= off_cnt + 3'd1;
  property p_near;
    base && near_thermal_limit |=> led_input && led_output && led_service && overtemp_warn_n_oe
      && !fault_oe && !output_good_n_oe;
  endproperty
  a_near: assert property (p_near) else $error("near thermal state wrong");
  property p_otw_idle;
    !near_thermal_limit && !thermal_shutdown |=> !overtemp_warn_n_oe;
  endproperty
  a_otw_idle: assert property (p_otw_idle) else $error("overtemp warning not idle");
  property p_hard;
    (fuse_blown || boost_fail || ov_latched) && !thermal_shutdown |=> led_input && !led_output && led_fault
      && fault_oe && output_good_n_oe;
  endproperty
  a_hard: assert property (p_hard) else $error("shutdown state wrong");
  property p_in_bad;
    !hard && input_present && !input_ok && !near_thermal_limit |=> !led_output && !led_service && !led_fault
      && output_good_n_oe && !fault_oe && !overtemp_warn_n_oe;
  endproperty
  a_in_bad: assert property (p_in_bad) else $error("input limit state wrong");
  property p_int;
    quiet && internal_fault && fan_fail == 2'b00 |=> led_fault && fault_oe && led_output && !output_good_n_oe;
  endproperty
  a_int: assert property (p_int) else $error("internal fault state wrong");
  property p_fan1;
    quiet && ^fan_fail |=> led_fault && fault_oe && led_output && !output_good_n_oe;
  endproperty
  a_fan1: assert property (p_fan1) else $error("single fan state wrong");
  property p_fan2;
    &fan_fail |=> fault_oe && output_good_n_oe && !led_output;
  endproperty
  a_fan2: assert property (p_fan2) else $error("double fan did not shut down");
  property p_od;
    !fault_out && !output_good_n_out && !overtemp_warn_n_out;
  endproperty
  a_od: assert property (p_od) else $error("alarm driver drives high");
  property p_off;
    off_cnt == 3'd7 && !rs485_mode |-> !main_output_en;
  endproperty
  a_off: assert property (p_off) else $error("output on with pin high");
  property p_loss;
    output_loss_predict |=> output_good_n_oe;
  endproperty
  a_loss: assert property (p_loss) else $error("power good kept on loss");
  property p_mode;
    $stable(link_sel_pin)[*5] |-> rs485_mode == link_sel_pin;
  endproperty
  a_mode: assert property (p_mode) else $error("link mode wrong");
  property p_addr;
    ($stable(slot_addr_level) && $stable(shelf_addr_level))[*5] |-> bus_addr_low == (slot_addr_level ^ shelf_addr_level);
  endproperty
  a_addr: assert property (p_addr) else $error("address bits wrong");
  c_near: cover property (base && near_thermal_limit);
  c_ovl: cover property (quiet && overload);
  c_fan: cover property (quiet && ^fan_fail);
endmodule
bind alarm_led_status alarm_led_checker chk (.*);

// *** verification/alarm_line_monitor.sv ***
// Purpose: Shelf-side pull-ups turning open-drain alarm drivers into pin levels
// Assumes: Every alarm line is pulled up to the logic rail
// Notes: A released line reads high, never the last driven value
`timescale 1ns/1ps
module alarm_line_monitor (
  // Open-drain drivers
  input  wire fault_out,
  input  wire fault_oe,
  input  wire output_good_n_out,
  input  wire output_good_n_oe,
  input  wire overtemp_warn_n_out,
  input  wire overtemp_warn_n_oe,
  // Pin levels
  output wire fault_n,
  output wire output_good_n,
  output wire overtemp_warn_n
);
  assign fault_n         = fault_oe ? fault_out : 1'b1;
  assign output_good_n   = output_good_n_oe ? output_good_n_out : 1'b1;
  assign overtemp_warn_n = overtemp_warn_n_oe ? overtemp_warn_n_out : 1'b1;
endmodule

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the alarm and LED status block
// Assumes: Short blink and pulse counts via CLK_HZ of 4000
// Notes: Pins are sampled at the falling edge, where they are settled
`timescale 1ns/1ps
`include "alarm_led_regs.vh"
module testbench;
  reg          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]   s_axi_awaddr, s_axi_araddr;
  reg  [31:0]  s_axi_wdata, rd;
  reg  [3:0]   s_axi_wstrb, slot_addr_level, shelf_addr_level;
  reg          on_off_pin_n, link_sel_pin;
  reg  [16:0]  c;
  reg  [30:0]  e;
  reg  [1:0]   rr;
  wire         input_ok, input_present, near_thermal_limit, thermal_shutdown, fuse_blown, boost_fail, ov_latched,
               overload, internal_fault, standby, output_loss_predict, service_request, comm_lost, oring_test_done,
               cmd_error, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, led_input,
               led_output, led_service, led_fault, fault_out, fault_oe, output_good_n_out, output_good_n_oe,
               overtemp_warn_n_out, overtemp_warn_n_oe, presence_out, main_output_en, rs485_mode, port0_alert_n,
               port1_alert_n, fault_n, output_good_n, overtemp_warn_n;
  wire [1:0]   fan_fail, s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [3:0]   bus_addr_low;
  wire [6:0]   st = {led_input, led_output, led_service, led_fault, ~fault_n, ~output_good_n, ~overtemp_warn_n};
  integer      failures, n_tests, seed, i, k;
  assign {input_ok, input_present, near_thermal_limit, thermal_shutdown, fan_fail, fuse_blown, boost_fail,
    ov_latched, overload, internal_fault, standby, output_loss_predict, service_request, comm_lost,
    oring_test_done, cmd_error} = c;
  alarm_led_status #(.CLK_HZ(4000), .BLINK_HZ(1), .PULSE_MS(1)) DUT (.*);
  alarm_line_monitor pull (.*);
  // Conditions, expected state and compare mask for each table row
  function [30:0] row(input integer n);
    case (n)
      1: row = {17'h1_C000, 7'h71, 7'h7F};
      2: row = {17'h1_A000, 7'h5F, 7'h7F};
      3: row = {17'h1_9800, 7'h4E, 7'h7F};
      4: row = {17'h1_8800, 7'h6C, 7'h7F};
      5: row = {17'h1_8400, 7'h4E, 7'h7F};
      6: row = {17'h1_8200, 7'h4E, 7'h7F};
      7: row = {17'h1_8100, 7'h4E, 7'h7F};
      8: row = {17'h0_8000, 7'h02, 7'h3F};
      9: row = {17'h1_8080, 7'h40, 7'h5D};
      10: row = {17'h1_8040, 7'h6C, 7'h7F};
      11: row = {17'h1_8008, 7'h60, 7'h6F};
      12: row = {17'h1_8010, 7'h02, 7'h02};
      13: row = {17'h1_8020, 7'h42, 7'h7F};
      default: row = {17'h1_8000, 7'h60, 7'h7F};
    endcase
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Counts level changes of one status bit over n cycles
  task flips(input integer n, input integer b, input integer exp);
    integer f, j;
    reg     p;
    begin
      f = 0;
      @(negedge aclk);
      p = st[b];
      for (j = 0; j < n; j = j + 1)
      begin
        @(negedge aclk);
        if (st[b] !== p)
          f = f + 1;
        p = st[b];
      end
      chk(f, exp, "toggles");
      @(posedge aclk);
    end
  endtask
  // One register access; w selects write, otherwise read into rd and rr
  task bus(input w, input [7:0] a, input [31:0] d);
    reg ta, tw, done;
    begin
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      while (!done)
      begin
        @(negedge aclk);
        ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
        tw = s_axi_wready & s_axi_wvalid;
        done = w ? s_axi_bvalid : s_axi_rvalid;
        rd = s_axi_rdata;
        rr = w ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
        if (ta)
          {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
        if (tw)
          s_axi_wvalid <= 1'b0;
        if (done)
          {s_axi_bready, s_axi_rready} <= 2'b00;
      end
    end
  endtask
  task test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Whole run needs about 16500 cycles
  initial
  begin
    #500000;
    failures = failures + 1;
    test_done;
  end
  initial
  begin
    {failures, n_tests, seed} = {32'd0, 32'd0, 32'd81};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
    {on_off_pin_n, link_sel_pin, slot_addr_level, shelf_addr_level} = 10'h000;
    c = 17'h1_8000;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 44; k = k + 1)
    begin
      i = (k < 14) ? k : {$random(seed)} % 14;
      e = row(i);
      c <= e[30:14];
      {slot_addr_level, shelf_addr_level} <= $random(seed);
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk(st & e[6:0], e[13:7] & e[6:0], "leds");
      chk(bus_addr_low, slot_addr_level ^ shelf_addr_level, "address");
      chk(presence_out, 1'b0, "presence");
      @(posedge aclk);
    end
    for (k = 0; k < 4; k = k + 1)
    begin
      e = row(k == 0 ? 8 : k == 3 ? 11 : 9);
      c <= e[30:14];
      repeat (4) @(posedge aclk);
      flips(k == 2 ? 40 : 4000, k == 0 ? 6 : k == 1 ? 5 : k == 2 ? 1 : 4, k == 2 ? 10 : 2);
    end
    link_sel_pin <= 1'b1;
    c <= 17'h1_8004;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(rs485_mode, 1'b1, "link mode");
    chk(st & 7'h77, 7'h60, "comm leds");
    flips(4000, 3, 2);
    link_sel_pin <= 1'b0;
    c <= 17'h1_8000;
    on_off_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk(main_output_en, 1'b0, "output off");
    @(posedge aclk);
    on_off_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk(main_output_en, 1'b1, "output on");
    bus(1, `OFS_CMD, 32'h0000_0004);
    bus(0, `OFS_FAULT_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_017F, "sticky");
    bus(1, `OFS_CMD, 32'h0000_0002);
    bus(1, `OFS_CMD, 32'h0000_0001);
    @(negedge aclk);
    chk({port0_alert_n, port1_alert_n}, 2'b10, "alerts");
    @(posedge aclk);
    c <= 17'h1_8043;
    @(posedge aclk);
    c <= 17'h1_8000;
    bus(0, `OFS_FAULT_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0380, "latched");
    bus(0, `OFS_BUS_STATUS, 32'h0000_0000);
    chk(rd[7:0], 8'h11, "bus status");
    bus(1, `OFS_OC_RESP, 32'h0000_00A4);
    bus(1, `OFS_OT_RESP, 32'h0000_0052);
    bus(1, `OFS_CMD, 32'h0000_0003);
    bus(0, `OFS_FAULT_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0380, "kept");
    bus(1, `OFS_CMD, 32'h0000_0002);
    bus(0, `OFS_FAULT_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cleared");
    bus(0, `OFS_BUS_STATUS, 32'h0000_0000);
    chk(rd[8:0], 9'h010, "bus clear");
    @(negedge aclk);
    chk({port0_alert_n, port1_alert_n}, 2'b10, "alert kept");
    bus(0, `OFS_OC_RESP, 32'h0000_0000);
    chk(rd[7:0], 8'hA4, "oc resp");
    bus(0, `OFS_OT_RESP, 32'h0000_0000);
    chk(rd[7:0], 8'h52, "ot resp");
    c <= 17'h1_8040;
    bus(1, `OFS_CMD, 32'h0000_0002);
    bus(0, `OFS_FAULT_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0100, "reassert");
    c <= 17'h1_8000;
    bus(0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
    chk(rr, `SLVERR_RESP, "unmapped rsp");
    bus(1, `OFS_CTRL, 32'h0000_0001);
    {link_sel_pin, on_off_pin_n} <= 2'b11;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk(main_output_en, 1'b0, "analog off");
    test_done;
  end
endmodule
